// *** verilog/ept_params.svh ***
`ifndef EPT_PARAMS_SVH
`define EPT_PARAMS_SVH
// How it works
// - Load position starts equal to motor position, unless a multi-turn absolute encoder.
// - Shaft angle is reported relative to a programmable zero offset, in counts from 0 to four times the line count minus one.
// - Shaft speed is computed from encoder edges and readable in RPM.
// - Motor angle before gearbox and load angle after gearbox are reported separately.
// - Turn counter counts full motor turns and starts at zero without multi-turn.
// - Multi-turn alignment sets turn counter low 12 bits to encoder turns; counting continues.
// - Absolute encoder alignment loads slow absolute position into fast incremental tracking.
// - Alignment status uses codes 0 to 9 from not required to warning.
// - A non-absolute encoder type reports the not-required alignment code.
// - Several alignment attempts are made, then the failed state is held.
// - After failure, alignment restarts on reset, encoder type change, line count write or retry request.
// - Retry request is cleared by hardware when alignment has been carried out.
// - Edge counter increments on every encoder edge and is zero after reset.
// - While the edge counter clear setting is true, the edge counter is held zero.
// - Quadrature A and B, 90 degrees apart, give direction from their combined state.
// - Speed in hertz is edges per second over four times the line count.
// - Failed or warning alignment raises an error when the drive is started.
// - Direction swap negates measured speed and reverses the position count.
// - Encoder type code 0 is quadrature and 1 is clock/direction, codes 0 to 9.
`define EPT_A_CTRL 8'h00
`define EPT_A_LINES 8'h04
`define EPT_A_OFS 8'h08
`define EPT_A_EDGES 8'h0C
`define EPT_A_ANGLE 8'h10
`define EPT_A_LOAD 8'h14
`define EPT_A_TURNS 8'h18
`define EPT_A_SPEED 8'h1C
`define EPT_A_ALIGN 8'h20
`define EPT_C_CLR 0
`define EPT_C_SWAP 1
`define EPT_C_RETRY 2
`define EPT_C_TYPE 7:4
`define EPT_C_SHIFT 11:8
`define EPT_S_STATE 3:0
`define EPT_S_TRIES 7:4
`define EPT_S_ERR 8
`define EPT_LINES_RST 18'h00800
`define EPT_LINES_MIN 32'h000000FA
`define EPT_TYPE_RST 4'h3
`define EPT_TYPE_CDIR 4'h1
`define EPT_TYPE_ABS_ST 4'h7
`define EPT_TYPE_ABS_MT 4'h8
`define EPT_TRIES 4'h3
`define EPT_ALIGN_TOL 20'h00004
`define EPT_CLK_MHZ 100
`define EPT_WIN_US 1000
`define EPT_WIN_CYC (`EPT_WIN_US * `EPT_CLK_MHZ)
`define EPT_RPM_K (60000000 / (4 * `EPT_WIN_US))
`endif

// *** verilog/ept_pkg.sv ***
package ept_pkg;
  // Alignment status codes as software reads them.
  typedef enum logic [3:0] {
    ALN_NOT_REQ = 4'h0,
    ALN_DRV_BUSY = 4'h1,
    ALN_MOT_MOVE = 4'h2,
    ALN_ENC_FAULT = 4'h3,
    ALN_IN_PROG = 4'h4,
    ALN_ID_POS = 4'h5,
    ALN_DONE = 4'h6,
    ALN_LOST = 4'h7,
    ALN_FAILED = 4'h8,
    ALN_WARN = 4'h9
  } ept_align_t;

  // State of the pin decoder.
  typedef struct packed {
    logic a1;
    logic b1;
    logic a2;
    logic b2;
    logic pa;
    logic pb;
    logic step;
    logic dir;
  } ept_dec_st_t;

  // State of the tracker.
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic clr;
    logic swap;
    logic retry;
    logic [3:0] etype;
    logic [3:0] shift;
    logic [17:0] lines;
    logic [19:0] ofs;
    logic [31:0] edges;
    logic [19:0] pos;
    logic [31:0] turns;
    logic [31:0] load;
    logic [19:0] win;
    logic [31:0] wsum;
    logic dbusy;
    logic dneg;
    logic [4:0] dcnt;
    logic [31:0] dnum;
    logic [31:0] drem;
    logic [31:0] dq;
    logic [31:0] rpm;
    ept_align_t align;
    logic [3:0] tries;
    logic err;
  } ept_top_st_t;
endpackage : ept_pkg

// *** verilog/ept_quad_dec.sv ***
`timescale 1ns/1ns
module ept_quad_dec (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic clk_dir_mode,
  output logic step,
  output logic dir
);
  import ept_pkg::*;

  ept_dec_st_t q;
  ept_dec_st_t n;

  // Synchronise the pins, then compare the stable pair with its previous value.
  always_comb begin
    n = q;
    n.a1 = enc_a;
    n.b1 = enc_b;
    n.a2 = q.a1;
    n.b2 = q.b1;
    n.pa = q.a2;
    n.pb = q.b2;
    if (clk_dir_mode) begin
      n.step = q.a2 && !q.pa;
      n.dir = q.b2;
    end else begin
      n.step = (q.a2 ^ q.pa) ^ (q.b2 ^ q.pb);
      n.dir = q.pa ^ q.b2;
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign step = q.step;
  assign dir = q.dir;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_quad_fwd: assert property (!clk_dir_mode && !q.pa && !q.pb && !q.a2 && q.b2
    |=> step && dir) else $error("Forward quadrature edge not decoded.");
  a_quad_rev: assert property (!clk_dir_mode && !q.pa && !q.pb && q.a2 && !q.b2
    |=> step && !dir) else $error("Reverse quadrature edge not decoded.");
  a_quad_double: assert property (!clk_dir_mode && (q.a2 != q.pa) && (q.b2 != q.pb)
    |=> !step) else $error("Double change counted as an edge.");
  a_sync_delay: assert property (!clk_dir_mode && $rose(enc_a) && !enc_b ##1 !enc_b && enc_a
    ##1 !enc_b && enc_a |-> !step) else $error("Pin edge seen before two stages.");
endmodule : ept_quad_dec

// *** verilog/ept_top.sv ***
`timescale 1ns/1ns
`include "ept_params.svh"
module ept_top #(
  parameter int WIN_CYC = `EPT_WIN_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic abs_valid,
  input wire logic abs_fault,
  input wire logic [19:0] abs_pos,
  input wire logic [11:0] abs_turns,
  input wire logic drive_running,
  input wire logic motor_stopped,
  output ept_pkg::ept_align_t abs_align_state,
  output logic drive_start_error
);
  import ept_pkg::*;

  ept_top_st_t q;
  ept_top_st_t n;
  logic dec_step;
  logic dec_dir;
  logic fwd;
  logic acc;
  logic wr;
  logic rst_al;
  logic is_abs;
  logic is_mt;
  logic fin;
  logic ok;
  logic [19:0] l4;
  logic [19:0] diff;
  logic [31:0] mag;
  logic [63:0] prod;
  logic [31:0] rem;

  // Pin synchroniser and edge decoder.
  ept_quad_dec u_dec (
    .pclk(pclk),
    .presetn(presetn),
    .enc_a(enc_a),
    .enc_b(enc_b),
    .clk_dir_mode(q.etype == `EPT_TYPE_CDIR),
    .step(dec_step),
    .dir(dec_dir)
  );

  // Next state of bus slave, counters, speed divider and alignment machine.
  always_comb begin
    n = q;
    fwd = dec_dir ^ q.swap;
    l4 = {q.lines, 2'b00};
    acc = psel && penable && q.pready;
    wr = acc && pwrite && !q.pslverr;
    is_abs = (q.etype == `EPT_TYPE_ABS_ST) || (q.etype == `EPT_TYPE_ABS_MT);
    is_mt = q.etype == `EPT_TYPE_ABS_MT;
    fin = (q.align == ALN_DONE) || (q.align == ALN_WARN) || (q.align == ALN_FAILED);
    diff = 20'h00000;
    ok = 1'b0;
    mag = q.wsum[31] ? 32'(-q.wsum) : q.wsum;
    prod = {32'h0, mag} * 64'(`EPT_RPM_K);
    rem = {q.drem[30:0], q.dnum[31]};
    // A write that changes the encoder type, or any write of the line count, restarts alignment.
    rst_al = wr && (((paddr == `EPT_A_CTRL) && (pwdata[`EPT_C_TYPE] != q.etype))
      || (paddr == `EPT_A_LINES));

    // Access phase: answer one cycle after it opens, with data and error.
    n.pready = psel && penable && !q.pready;
    n.pslverr = 1'b0;
    n.prdata = 32'h00000000;
    if (n.pready) begin
      case (paddr)
        `EPT_A_CTRL: begin
          n.prdata[`EPT_C_CLR] = q.clr;
          n.prdata[`EPT_C_SWAP] = q.swap;
          n.prdata[`EPT_C_RETRY] = q.retry;
          n.prdata[`EPT_C_TYPE] = q.etype;
          n.prdata[`EPT_C_SHIFT] = q.shift;
        end
        `EPT_A_LINES: begin
          n.prdata = {14'h0000, q.lines};
          n.pslverr = pwrite && ((pwdata < `EPT_LINES_MIN) || (pwdata[31:18] != 14'h0000));
        end
        `EPT_A_OFS: begin
          n.prdata = {12'h000, q.ofs};
          n.pslverr = pwrite && (pwdata > {12'h000, l4});
        end
        `EPT_A_EDGES: begin
          n.prdata = q.edges;
          n.pslverr = pwrite;
        end
        `EPT_A_ANGLE: begin
          n.prdata = {12'h000, (q.pos < q.ofs) ? q.pos - q.ofs + l4 : q.pos - q.ofs};
          n.pslverr = pwrite;
        end
        `EPT_A_LOAD: begin
          n.prdata = 32'($signed(q.load) >>> q.shift);
          n.pslverr = pwrite;
        end
        `EPT_A_TURNS: begin
          n.prdata = q.turns;
          n.pslverr = pwrite;
        end
        `EPT_A_SPEED: begin
          n.prdata = q.rpm;
          n.pslverr = pwrite;
        end
        `EPT_A_ALIGN: begin
          n.prdata[`EPT_S_STATE] = q.align;
          n.prdata[`EPT_S_TRIES] = q.tries;
          n.prdata[`EPT_S_ERR] = q.err;
          n.pslverr = pwrite;
        end
        default: begin
          n.pslverr = 1'b1;
        end
      endcase
    end

    // Edge counter, held at zero while the clear setting is true.
    if (q.clr) begin
      n.edges = 32'h00000000;
    end else if (dec_step) begin
      n.edges = q.edges + 32'h00000001;
    end

    // Angle within the turn, turn counter and load position follow each edge.
    if (dec_step) begin
      if (fwd) begin
        n.load = q.load + 32'h00000001;
        n.wsum = q.wsum + 32'h00000001;
        if (q.pos >= l4 - 20'h00001) begin
          n.pos = 20'h00000;
          n.turns = q.turns + 32'h00000001;
        end else begin
          n.pos = q.pos + 20'h00001;
        end
      end else begin
        n.load = q.load - 32'h00000001;
        n.wsum = q.wsum - 32'h00000001;
        if ((q.pos == 20'h00000) || (q.pos >= l4)) begin
          n.pos = l4 - 20'h00001;
          n.turns = q.turns - 32'h00000001;
        end else begin
          n.pos = q.pos - 20'h00001;
        end
      end
    end

    // Restoring divider: edges per window times the scale, over the line count.
    if (q.dbusy) begin
      n.dnum = {q.dnum[30:0], 1'b0};
      n.drem = (rem >= {14'h0000, q.lines}) ? rem - {14'h0000, q.lines} : rem;
      n.dq = {q.dq[30:0], rem >= {14'h0000, q.lines}};
      n.dcnt = q.dcnt + 5'h01;
      if (q.dcnt == 5'h1F) begin
        n.dbusy = 1'b0;
        n.rpm = q.dneg ? 32'(-n.dq) : n.dq;
      end
    end

    // Close each speed window and start a division on its signed edge sum.
    if (q.win == 20'(WIN_CYC - 1)) begin
      n.win = 20'h00000;
      n.wsum = n.wsum - q.wsum;
      n.dnum = prod[31:0];
      n.dneg = q.wsum[31];
      n.dbusy = 1'b1;
      n.dcnt = 5'h00;
      n.drem = 32'h00000000;
      n.dq = 32'h00000000;
    end else begin
      n.win = q.win + 20'h00001;
    end

    // Alignment of the absolute position with the incremental tracking.
    if (!is_abs) begin
      n.align = ALN_NOT_REQ;
      n.tries = 4'h0;
    end else if (rst_al || (q.retry && (fin || (q.align == ALN_LOST)))
      || (q.align == ALN_NOT_REQ) || (q.align == ALN_DRV_BUSY)
      || (q.align == ALN_MOT_MOVE)) begin
      n.tries = 4'h0;
      if (drive_running) begin
        n.align = ALN_DRV_BUSY;
      end else if (!motor_stopped) begin
        n.align = ALN_MOT_MOVE;
      end else begin
        n.align = ALN_IN_PROG;
      end
    end else begin
      case (q.align)
        ALN_IN_PROG, ALN_ID_POS: begin
          if (abs_valid && !abs_fault && (q.align == ALN_IN_PROG)) begin
            // The absolute sample overrides any edge seen in this cycle.
            n.pos = abs_pos;
            if (is_mt) begin
              n.turns = {20'h00000, abs_turns};
              n.load = 32'({20'h00000, abs_turns} * {12'h000, l4}) + {12'h000, abs_pos};
            end
            n.align = ALN_ID_POS;
          end else if (abs_valid || abs_fault) begin
            diff = abs_pos - q.pos;
            ok = !abs_fault && ((diff <= `EPT_ALIGN_TOL) || (-diff <= `EPT_ALIGN_TOL));
            if (ok) begin
              n.align = (q.tries == 4'h0) ? ALN_DONE : ALN_WARN;
            end else begin
              n.tries = q.tries + 4'h1;
              if (q.tries == `EPT_TRIES - 4'h1) begin
                n.align = ALN_FAILED;
              end else begin
                n.align = abs_fault ? ALN_ENC_FAULT : ALN_IN_PROG;
              end
            end
          end
        end
        ALN_ENC_FAULT: begin
          n.align = abs_fault ? ALN_ENC_FAULT : ALN_IN_PROG;
        end
        ALN_DONE: begin
          n.align = abs_fault ? ALN_LOST : ALN_DONE;
        end
        default: begin
          n.align = q.align;
        end
      endcase
    end

    // Retry is dropped when an attempt sequence ends; a write of one wins.
    if (((n.align == ALN_DONE) || (n.align == ALN_WARN) || (n.align == ALN_FAILED)) && !fin) begin
      n.retry = 1'b0;
    end
    n.err = drive_running && ((q.align == ALN_FAILED) || (q.align == ALN_WARN));

    // Register writes, taken at the edge where the access completes.
    if (wr) begin
      case (paddr)
        `EPT_A_CTRL: begin
          n.clr = pwdata[`EPT_C_CLR];
          n.swap = pwdata[`EPT_C_SWAP];
          n.retry = pwdata[`EPT_C_RETRY] | n.retry;
          n.etype = pwdata[`EPT_C_TYPE];
          n.shift = pwdata[`EPT_C_SHIFT];
        end
        `EPT_A_LINES: begin
          n.lines = pwdata[17:0];
        end
        `EPT_A_OFS: begin
          n.ofs = pwdata[19:0];
        end
        default: begin
          n.ofs = q.ofs;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.etype <= `EPT_TYPE_RST;
      q.lines <= `EPT_LINES_RST;
    end else begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign abs_align_state = q.align;
  assign drive_start_error = q.err;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_last_miss;
    (q.align == ALN_ID_POS) && abs_valid && !abs_fault && (q.tries == `EPT_TRIES - 4'h1)
      && !rst_al && is_abs && !ok;
  endsequence

  sequence s_settled;
    !fin && !rst_al && !(wr && (paddr == `EPT_A_CTRL)) ##1 fin;
  endsequence

  a_apb_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("Bus answer not given after one wait cycle.");
  a_edge_clear: assert property (q.clr |=> q.edges == 32'h00000000)
    else $error("Edge counter not held at zero.");
  a_edge_count: assert property (dec_step && !q.clr |=> q.edges == $past(q.edges) + 1)
    else $error("Edge not counted.");
  a_turn_wrap: assert property (dec_step && fwd && (q.pos == l4 - 20'h00001) && !is_abs
    |=> (q.turns == $past(q.turns) + 1) && (q.pos == 20'h00000))
    else $error("Forward turn not counted.");
  a_not_req: assert property (!is_abs |=> abs_align_state == ALN_NOT_REQ)
    else $error("Alignment attempted on a non-absolute encoder.");
  a_fail_max: assert property (s_last_miss |=> (q.align == ALN_FAILED)
    ##1 ((q.align == ALN_FAILED) || $past(q.retry || rst_al || !is_abs)))
    else $error("Failed state not entered after the last attempt.");
  a_retry_auto: assert property (s_settled |-> !q.retry)
    else $error("Retry flag not cleared after alignment.");
  a_start_error: assert property (drive_running && (q.align == ALN_FAILED)
    |=> drive_start_error) else $error("Start error not raised.");
  a_mt_turns: assert property ((q.align == ALN_IN_PROG) && abs_valid && !abs_fault && is_mt
    && !rst_al && !q.retry |=> q.turns[11:0] == $past(abs_turns))
    else $error("Turn counter not aligned to encoder turns.");
endmodule : ept_top

// *** tb/ept_enc_model.sv ***
`timescale 1ns/1ns
module ept_enc_model (
  input wire logic pclk,
  output logic enc_a,
  output logic enc_b,
  output logic abs_valid,
  output logic abs_fault,
  output logic [19:0] abs_pos,
  output logic [11:0] abs_turns
);
  logic [1:0] ph = 2'h0;

  // The encoder lines rest low with no sample pending.
  initial begin
    enc_a = 1'b0;
    enc_b = 1'b0;
    abs_valid = 1'b0;
    abs_fault = 1'b0;
    abs_pos = 20'h00000;
    abs_turns = 12'h000;
  end

  // Steps A and B a quarter cycle apart; B leads when turning forward.
  task automatic move(input int n, input bit fwd, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      ph = fwd ? ph + 2'h1 : ph - 2'h1;
      enc_a <= ph[1];
      enc_b <= ph[1] ^ ph[0];
      repeat (gap - 1) @(posedge pclk);
    end
  endtask : move

  // Sends one absolute sample as a single-cycle strobe, then scrambles the lines.
  task automatic sample(input logic [19:0] p, input logic [11:0] t);
    @(posedge pclk);
    abs_valid <= 1'b1;
    abs_pos <= p;
    abs_turns <= t;
    @(posedge pclk);
    abs_valid <= 1'b0;
    abs_pos <= ~p;
    abs_turns <= ~t;
  endtask : sample

  // Raises or drops the encoder fault level.
  task automatic fault(input logic f);
    @(posedge pclk);
    abs_fault <= f;
  endtask : fault
endmodule : ept_enc_model

// *** tb/tb_encoder_position_tracker.sv ***
`timescale 1ns/1ns
`include "ept_params.svh"
module tb_encoder_position_tracker;
  import ept_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic enc_a;
  logic enc_b;
  logic abs_valid;
  logic abs_fault;
  logic [19:0] abs_pos;
  logic [11:0] abs_turns;
  logic drive_running = 1'b0;
  logic motor_stopped = 1'b1;
  ept_align_t abs_align_state;
  logic drive_start_error;
  logic [31:0] rd;
  logic er;
  int error_cnt = 0;
  int samples_checked = 0;

  // The clock toggles every half period of 5 ns.
  always #5 pclk = ~pclk;

  ept_top #(.WIN_CYC(200)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b), .abs_valid(abs_valid),
    .abs_fault(abs_fault), .abs_pos(abs_pos), .abs_turns(abs_turns),
    .drive_running(drive_running), .motor_stopped(motor_stopped),
    .abs_align_state(abs_align_state), .drive_start_error(drive_start_error));

  ept_enc_model enc (.pclk(pclk), .enc_a(enc_a), .enc_b(enc_b), .abs_valid(abs_valid),
    .abs_fault(abs_fault), .abs_pos(abs_pos), .abs_turns(abs_turns));

  // Compares one value and counts it.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is seen at an edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h1, {31'h0, pready});
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rdchk

  task automatic errchk(input logic [7:0] a, input logic [31:0] d, input logic exp);
    apb(1'b1, a, d);
    chk("slverr", {31'h0, exp}, {31'h0, er});
  endtask : errchk

  // Polls the status port for a bounded time, then compares it.
  task automatic wait_state(input logic [3:0] code);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (abs_align_state !== code && n < 200);
    chk("align state", {28'h0, code}, {28'h0, abs_align_state});
  endtask : wait_state

  task automatic drv(input logic run, input logic stop);
    @(posedge pclk);
    drive_running <= run;
    motor_stopped <= stop;
  endtask : drv

  // Register defaults and refused accesses.
  task automatic t_reset;
    rdchk(`EPT_A_CTRL, 32'h00000030, "ctrl");
    rdchk(`EPT_A_LINES, 32'h00000800, "lines");
    rdchk(`EPT_A_EDGES, 32'h0, "edges");
    rdchk(`EPT_A_TURNS, 32'h0, "turns");
    rdchk(`EPT_A_LOAD, 32'h0, "load");
    rdchk(`EPT_A_SPEED, 32'h0, "speed");
    wait_state(4'h0);
    errchk(`EPT_A_LINES, 32'h000000F9, 1'b1);
    errchk(`EPT_A_LINES, 32'h000000FA, 1'b0);
    errchk(`EPT_A_EDGES, 32'h00000001, 1'b1);
    errchk(8'h24, 32'h0, 1'b1);
    rdchk(8'h24, 32'h0, "unmapped read");
    chk("slverr", 32'h1, {31'h0, er});
    $display("test reset ends");
  endtask : t_reset

  // Full turns at 250 lines, clear, offset and direction swap.
  task automatic t_turns;
    enc.move(1000, 1'b1, 3);
    repeat (8) @(posedge pclk);
    rdchk(`EPT_A_EDGES, 32'd1000, "edges");
    rdchk(`EPT_A_TURNS, 32'd1, "turns");
    rdchk(`EPT_A_ANGLE, 32'd0, "angle");
    enc.move(1, 1'b0, 3);
    repeat (8) @(posedge pclk);
    rdchk(`EPT_A_TURNS, 32'd0, "turns");
    rdchk(`EPT_A_ANGLE, 32'd999, "angle");
    apb(1'b1, `EPT_A_CTRL, 32'h00000031);
    enc.move(2, 1'b1, 3);
    repeat (8) @(posedge pclk);
    rdchk(`EPT_A_EDGES, 32'd0, "edges held");
    errchk(`EPT_A_OFS, 32'd1001, 1'b1);
    errchk(`EPT_A_OFS, 32'd10, 1'b0);
    rdchk(`EPT_A_ANGLE, 32'd991, "angle ofs");
    apb(1'b1, `EPT_A_CTRL, 32'h00000032);
    enc.move(1, 1'b1, 3);
    repeat (8) @(posedge pclk);
    rdchk(`EPT_A_ANGLE, 32'd990, "angle swap");
    // Clock/direction mode: A rises once per four pin steps and B gives the direction.
    apb(1'b1, `EPT_A_CTRL, 32'h00000010);
    enc.move(4, 1'b1, 3);
    repeat (8) @(posedge pclk);
    rdchk(`EPT_A_ANGLE, 32'd991, "angle clkdir");
    enc.move(4, 1'b0, 3);
    repeat (8) @(posedge pclk);
    rdchk(`EPT_A_ANGLE, 32'd990, "angle clkdir rev");
    rdchk(`EPT_A_EDGES, 32'd3, "edges clkdir");
    $display("test turns ends");
  endtask : t_turns

  // 50 edges per 200-cycle window at 250 lines gives 3000 RPM.
  task automatic t_speed;
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, `EPT_A_CTRL, (s == 1) ? 32'h00000032 : 32'h00000030);
      fork
        enc.move(200, 1'b1, 4);
        begin
          repeat (700) @(posedge pclk);
          rdchk(`EPT_A_SPEED, (s == 1) ? -32'sd3000 : 32'sd3000, "speed");
        end
      join
    end
    $display("test speed ends");
  endtask : t_speed

  // Alignment states, retries, failure and start errors.
  task automatic t_align;
    apb(1'b1, `EPT_A_CTRL, 32'h00000080);
    wait_state(4'h4);
    enc.sample(20'd123, 12'd5);
    wait_state(4'h5);
    enc.sample(20'd123, 12'd5);
    wait_state(4'h6);
    rdchk(`EPT_A_TURNS, 32'd5, "turns");
    rdchk(`EPT_A_ANGLE, 32'd113, "angle");
    rdchk(`EPT_A_LOAD, 32'd5123, "load");
    apb(1'b1, `EPT_A_CTRL, 32'h00000280);
    rdchk(`EPT_A_LOAD, 32'd1280, "load shifted");
    enc.fault(1'b1);
    wait_state(4'h7);
    enc.fault(1'b0);
    apb(1'b1, `EPT_A_CTRL, 32'h00000084);
    for (int i = 0; i < 3; i++) begin
      wait_state(4'h4);
      enc.sample(20'd200, 12'd5);
      wait_state(4'h5);
      enc.sample(20'd600, 12'd5);
    end
    wait_state(4'h8);
    rdchk(`EPT_A_ALIGN, 32'h00000038, "align reg");
    rdchk(`EPT_A_CTRL, 32'h00000080, "retry");
    drv(1'b1, 1'b0);
    repeat (3) @(posedge pclk);
    chk("start error", 32'h1, {31'h0, drive_start_error});
    apb(1'b1, `EPT_A_CTRL, 32'h00000084);
    wait_state(4'h1);
    drv(1'b0, 1'b0);
    wait_state(4'h2);
    drv(1'b0, 1'b1);
    wait_state(4'h4);
    enc.fault(1'b1);
    wait_state(4'h3);
    enc.fault(1'b0);
    apb(1'b1, `EPT_A_CTRL, 32'h00000070);
    wait_state(4'h4);
    enc.sample(20'd300, 12'd0);
    wait_state(4'h5);
    enc.sample(20'd700, 12'd0);
    wait_state(4'h4);
    enc.sample(20'd300, 12'd0);
    wait_state(4'h5);
    enc.sample(20'd300, 12'd0);
    wait_state(4'h9);
    rdchk(`EPT_A_ALIGN, 32'h00000019, "align reg");
    drv(1'b1, 1'b1);
    repeat (3) @(posedge pclk);
    chk("start error", 32'h1, {31'h0, drive_start_error});
    drv(1'b0, 1'b1);
    apb(1'b1, `EPT_A_CTRL, 32'h00000030);
    wait_state(4'h0);
    $display("test align ends");
  endtask : t_align

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  // Main sequence after six reset cycles.
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_turns;
    t_speed;
    t_align;
    stop_test;
  end

  // Cuts a hang short well beyond the expected run time.
  initial begin
    #200000;
    error_cnt++;
    stop_test;
  end
endmodule : tb_encoder_position_tracker
